//--- include/acsp_pkg.sv
package acsp_pkg;
    // ==========================================================
    // instruction layout
    // ==========================================================
    localparam int INSTR_BITS = 16;
    localparam int BYTE_BITS = 8;
    localparam int ADDR_BITS = 13;
    localparam int RW_POS = 15;
    localparam int WLEN_HI_POS = 14;
    localparam int WLEN_LO_POS = 13;
    localparam logic [1:0] WLEN_STREAM = 2'h3;
    // ==========================================================
    // register space
    // ==========================================================
    localparam logic [12:0] CFG_ADDR = 13'h0000;
    localparam logic [12:0] XFER_ADDR = 13'h00FF;
    localparam logic [7:0] XFER_GO = 8'h01;
    localparam logic [7:0] CFG_RESET = 8'h18;
    localparam int CFG_LSB_HI_POS = 6;
    localparam int CFG_LSB_LO_POS = 1;
    localparam logic [3:0] LAST_INSTR_BIT = 4'hF;
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;
    localparam logic [3:0] FIRST_BYTE_END = 4'h8;
    // ==========================================================
    // frame phases
    // ==========================================================
    typedef enum logic [1:0] {
        ACSP_IDLE = 2'b00,
        ACSP_INSTR = 2'b01,
        ACSP_DATA = 2'b10,
        ACSP_DONE = 2'b11
    } acsp_phase_t;

    function automatic logic [7:0] acsp_rev8(input logic [7:0] v);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7-i];
        end
        return r;
    endfunction : acsp_rev8

    function automatic logic [15:0] acsp_rev16(input logic [15:0] v);
        logic [15:0] r;
        r = '0;
        for (int i = 0; i < 16; i++) begin
            r[i] = v[15-i];
        end
        return r;
    endfunction : acsp_rev16
endpackage : acsp_pkg

//--- include/acsp_sync_if.sv
`timescale 1ns/1ps
interface acsp_sync_if #(
    parameter int W = 3
);
    logic [W-1:0] raw;
    logic [W-1:0] sync;
    modport sync_side (input raw, output sync);
    modport user (output raw, input sync);
endinterface : acsp_sync_if

//--- design/acsp_sync.sv
`timescale 1ns/1ps
module acsp_sync import acsp_pkg::*; #(
    parameter int W = 3,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    acsp_sync_if.sync_side bus
);
    // ==========================================================
    // two-stage synchroniser
    // ==========================================================
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } acsp_sync_st_t;

    acsp_sync_st_t st_q;
    acsp_sync_st_t st_d;

    always_comb begin
        st_d.s1 = bus.raw;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_q <= '{s1: RST_VAL, s2: RST_VAL};
        end else begin
            st_q <= st_d;
        end
    end

    assign bus.sync = st_q.s2;
endmodule : acsp_sync

//--- design/acsp_top.sv
// Summary of operation
// - chip_select_n is active low; transfers happen only while it is low.
// - frame opens on chip_select_n fall; bits taken on serial clock rises.
// - serial clock from host shifts every bit in and out.
// - chip_select_n held low keeps streaming consecutive data bytes in streaming mode only.
// - chip_select_n high at a byte boundary stalls, frame kept, except at a data byte boundary in streaming mode, where it ends the frame.
// - chip_select_n high: data pin released, secondary functions enabled.
// - every frame opens with a 16-bit instruction shifted in.
// - word length bits set the data phase length.
// - data after the instruction moves in 8-bit words, one byte each.
// - instruction bit 15 picks register write or readback; it leads when MSB first, trails when LSB first.
// - on readback the data pin turns to output after instruction.
// - data pin input on writes, output on readback; others inputs.
// - MSB first after reset; LSB first selectable in config register.
// - byte organised register space, every address readable; every address but 0xFF writable.
// - writing 0x01 to 0xFF applies shadow copies at once; bit autoclears.
`timescale 1ns/1ps
module acsp_top import acsp_pkg::*; #(
    parameter int AW = 8
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_sclk,
    input wire logic i_chip_select_n,
    input wire logic i_sdio_i,
    output logic o_sdio_o,
    output logic o_sdio_oe,
    output logic o_sec_fn_en,
    output logic o_lsb_first,
    output logic o_update,
    output logic o_busy,
    input wire logic [AW-1:0] i_look_addr,
    output logic [7:0] o_look_data
);
    // ==========================================================
    // pin synchronisation
    // ==========================================================
    acsp_sync_if #(.W(3)) u_if ();
    assign u_if.raw = {i_sclk, i_chip_select_n, i_sdio_i};

    acsp_sync #(.W(3), .RST_VAL(3'h2)) u_sync (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .bus(u_if.sync_side)
    );

    logic sclk_s;
    logic csn_s;
    logic sdi_s;
    assign sclk_s = u_if.sync[2];
    assign csn_s = u_if.sync[1];
    assign sdi_s = u_if.sync[0];

    // ==========================================================
    // state
    // ==========================================================
    localparam int DEPTH = 1 << AW;

    typedef struct packed {
        logic sclk_p;
        logic csn_p;
        acsp_phase_t phase;
        logic rd;
        logic [1:0] wlen;
        logic [1:0] nbytes;
        logic [ADDR_BITS-1:0] addr;
        logic [3:0] bitcnt;
        logic [15:0] sh_in;
        logic [7:0] sh_out;
        logic lsb_first;
        logic sdo;
        logic sdo_oe;
        logic sec_fn;
        logic xfer;
        logic busy;
        logic [7:0] look;
        logic [DEPTH-1:0][7:0] mem;
        logic [DEPTH-1:0][7:0] act;
    } acsp_st_t;

    acsp_st_t st_q;
    acsp_st_t st_d;

    logic sclk_rise;
    logic sclk_fall;
    logic csn_fall;
    logic csn_rise;
    assign sclk_rise = sclk_s & ~st_q.sclk_p;
    assign sclk_fall = ~sclk_s & st_q.sclk_p;
    assign csn_fall = ~csn_s & st_q.csn_p;
    assign csn_rise = csn_s & ~st_q.csn_p;

    always_comb begin
        logic [15:0] sh;
        logic [15:0] word;
        logic [7:0] dbyte;
        logic [ADDR_BITS-1:0] nxt;
        logic at_bound;
        sh = '0;
        word = '0;
        dbyte = '0;
        nxt = '0;
        at_bound = 1'b0;
        st_d = st_q;
        st_d.sclk_p = sclk_s;
        st_d.csn_p = csn_s;
        st_d.xfer = 1'b0;
        st_d.look = st_q.act[i_look_addr];
        st_d.sec_fn = csn_s;
        // start only with chip select low
        // new frame on chip select fall
        if (csn_fall && (st_q.phase == ACSP_IDLE || st_q.phase == ACSP_DONE))
        begin
            st_d.phase = ACSP_INSTR;
            st_d.bitcnt = '0;
            st_d.nbytes = '0;
        end
        at_bound = (st_q.phase == ACSP_INSTR && st_q.bitcnt == FIRST_BYTE_END)
            || (st_q.phase == ACSP_DATA && st_q.bitcnt == '0
                && st_q.wlen != WLEN_STREAM);
        if (csn_rise && !at_bound) begin
            st_d.phase = ACSP_IDLE;
        end
        // shift on host clock rising edges
        if (sclk_rise && !csn_s) begin
            sh = {st_q.sh_in[14:0], sdi_s};
            st_d.sh_in = sh;
            st_d.bitcnt = st_q.bitcnt + 4'h1;
            unique case (st_q.phase)
                ACSP_INSTR: begin
                    if (st_q.bitcnt == LAST_INSTR_BIT) begin
                        word = st_q.lsb_first ? acsp_rev16(sh) : sh;
                        st_d.rd = word[RW_POS];
                        st_d.wlen = {word[WLEN_HI_POS], word[WLEN_LO_POS]};
                        st_d.addr = word[ADDR_BITS-1:0];
                        st_d.bitcnt = '0;
                        st_d.phase = ACSP_DATA;
                        st_d.sh_out = st_q.mem[word[AW-1:0]];
                    end
                end
                ACSP_DATA: begin
                    if (st_q.rd) begin
                        st_d.sh_out = st_q.lsb_first ? {1'b0, st_q.sh_out[7:1]}
                            : {st_q.sh_out[6:0], 1'b0};
                    end
                    if (st_q.bitcnt == LAST_DATA_BIT) begin
                        st_d.bitcnt = '0;
                        dbyte = st_q.lsb_first ? acsp_rev8(sh[7:0]) : sh[7:0];
                        if (!st_q.rd && st_q.addr == XFER_ADDR) begin
                            if (dbyte == XFER_GO) begin
                                st_d.act = st_q.mem;
                                st_d.xfer = 1'b1;
                            end
                        end else if (!st_q.rd) begin
                            st_d.mem[st_q.addr[AW-1:0]] = dbyte;
                            if (st_q.addr == CFG_ADDR) begin
                                st_d.lsb_first = dbyte[CFG_LSB_HI_POS]
                                    | dbyte[CFG_LSB_LO_POS];
                            end
                        end
                        nxt = st_q.lsb_first ? st_q.addr + 13'h0001
                            : st_q.addr - 13'h0001;
                        st_d.addr = nxt;
                        st_d.sh_out = st_q.mem[nxt[AW-1:0]];
                        st_d.nbytes = st_q.nbytes + 2'h1;
                        if (st_q.wlen != WLEN_STREAM
                            && st_q.nbytes == st_q.wlen) begin
                            st_d.phase = ACSP_DONE;
                        end
                    end
                end
                ACSP_IDLE, ACSP_DONE: begin
                    st_d.bitcnt = st_q.bitcnt;
                end
            endcase
        end
        st_d.sdo_oe = !csn_s && st_d.phase == ACSP_DATA && st_d.rd;
        if (sclk_fall || (st_d.phase == ACSP_DATA && st_q.phase != ACSP_DATA))
        begin
            st_d.sdo = st_d.lsb_first ? st_d.sh_out[0] : st_d.sh_out[7];
        end
        st_d.busy = st_d.phase != ACSP_IDLE;
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_q <= '0;
            st_q.sclk_p <= 1'b0;
            st_q.csn_p <= 1'b1;
            st_q.sec_fn <= 1'b1;
            st_q.mem[0] <= CFG_RESET;
            st_q.act[0] <= CFG_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_sdio_o = st_q.sdo;
    assign o_sdio_oe = st_q.sdo_oe;
    assign o_sec_fn_en = st_q.sec_fn;
    assign o_lsb_first = st_q.lsb_first;
    assign o_update = st_q.xfer;
    assign o_busy = st_q.busy;
    assign o_look_data = st_q.look;
endmodule : acsp_top

//--- verification/acsp_top_monitor.sv
`timescale 1ns/1ps
module acsp_top_monitor import acsp_pkg::*; (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_sclk,
    input wire logic i_chip_select_n,
    input wire logic o_sdio_o,
    input wire logic o_sdio_oe,
    input wire logic o_sec_fn_en,
    input wire logic o_update,
    input wire logic o_busy
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);
    // ==========================================================
    // select sequences
    // ==========================================================
    sequence cs_held_hi;
        i_chip_select_n [*4];
    endsequence
    sequence cs_held_lo;
        !i_chip_select_n [*4];
    endsequence
    a_idle_sec_fn: assert property (cs_held_hi |-> o_sec_fn_en)
        else $error("secondary functions off while deselected");
    a_sel_sec_off: assert property (cs_held_lo |-> !o_sec_fn_en)
        else $error("secondary functions on while selected");
    a_oe_off_idle: assert property (o_sec_fn_en |-> !o_sdio_oe)
        else $error("data pin driven while deselected");
    a_update_pulse: assert property (o_update |=> !o_update)
        else $error("update pulse longer than one cycle");
    a_update_no_oe: assert property (o_update |-> !o_sdio_oe)
        else $error("update during readback");
    a_data_stable: assert property ($rose(i_sclk) && o_sdio_oe
        |=> $stable(o_sdio_o) [*2])
        else $error("read data moved after clock rise");
    a_busy_select: assert property ($rose(o_busy)
        |-> !$past(i_chip_select_n, 2))
        else $error("frame opened without select");
    a_oe_select: assert property ($rose(o_sdio_oe)
        |-> o_busy && !$past(i_chip_select_n, 2))
        else $error("data pin turned without select");
endmodule : acsp_top_monitor
bind acsp_top acsp_top_monitor mon_u (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_sclk(i_sclk),
    .i_chip_select_n(i_chip_select_n),
    .o_sdio_o(o_sdio_o),
    .o_sdio_oe(o_sdio_oe),
    .o_sec_fn_en(o_sec_fn_en),
    .o_update(o_update),
    .o_busy(o_busy)
);

//--- verification/acsp_host.sv
`timescale 1ns/1ps
module acsp_host import acsp_pkg::*; (
    input wire logic i_clk,
    input wire logic i_sdio_o,
    input wire logic i_sdio_oe,
    output logic o_sclk = 1'b0,
    output logic o_csn = 1'b1,
    output logic o_sdio
);
    logic hen = 1'b0;
    logic hbit = 1'b0;
    logic lsb = 1'b0;
    logic [7:0] wb[4];
    logic [7:0] rb[4];
    assign o_sdio = i_sdio_oe ? i_sdio_o : (hen ? hbit : ~hbit);
    task automatic wt(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : wt
    task automatic shift(input int w, input logic [15:0] v,
        output logic [15:0] r);
        int j;
        r = '0;
        for (int i = 0; i < w; i++) begin
            j = lsb ? i : w - 1 - i;
            hbit = v[j];
            wt(4);
            r[j] = o_sdio;
            o_sclk = 1'b1;
            wt(4);
            o_sclk = 1'b0;
        end
    endtask : shift
    task automatic frame(input logic rw, input logic [1:0] wl,
        input logic [12:0] a, input int n, input logic stall);
        logic [15:0] r;
        o_csn = 1'b0;
        hen = 1'b1;
        wt(1);
        shift(16, {rw, wl, a}, r);
        hen = !rw;
        for (int k = 0; k < n; k++) begin
            if (stall && k > 0) begin
                o_csn = 1'b1;
                wt(6);
                o_csn = 1'b0;
                wt(1);
            end
            shift(8, {8'h00, wb[k]}, r);
            rb[k] = r[7:0];
        end
        o_csn = 1'b1;
        hen = 1'b0;
        wt(8);
    endtask : frame
endmodule : acsp_host

//--- verification/tb.sv
`timescale 1ns/1ps
module tb import acsp_pkg::*;;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic sclk, csn, sdio, so, soe, sec, lsbf, upd, busy;
    logic [7:0] la = 8'h00;
    logic [7:0] ld;
    int error_cnt = 0;
    int n_tests = 0;
    int upd_cnt = 0;
    always #10 clk = ~clk;
    always @(posedge clk) if (upd === 1'b1) upd_cnt++;
    acsp_top #(.AW(8)) dut_u (.i_clk(clk), .i_resetn(rstn),
        .i_sclk(sclk), .i_chip_select_n(csn), .i_sdio_i(sdio),
        .o_sdio_o(so), .o_sdio_oe(soe), .o_sec_fn_en(sec),
        .o_lsb_first(lsbf), .o_update(upd), .o_busy(busy),
        .i_look_addr(la), .o_look_data(ld));
    acsp_host host_u (.i_clk(clk), .i_sdio_o(so), .i_sdio_oe(soe),
        .o_sclk(sclk), .o_csn(csn), .o_sdio(sdio));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic peek(input logic [7:0] a, input logic [7:0] e);
        la = a;
        host_u.wt(2);
        check(ld, e);
    endtask : peek
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        host_u.wb[0] = d;
        host_u.frame(1'b0, 2'h0, a, 1, 1'b0);
    endtask : wr
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (50000) @(posedge clk);
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        logic [15:0] r;
        repeat (8) @(posedge clk);
        #1 rstn = 1'b1;
        host_u.wt(4);
        check({5'h0, sec, lsbf, busy}, 8'h04);
        peek(CFG_ADDR[7:0], CFG_RESET);
        $display("test reset done");
        wr(13'h0010, 8'hA5);
        wr(XFER_ADDR, 8'h02);
        check(upd_cnt[7:0], 8'h00);
        wr(XFER_ADDR, XFER_GO);
        check(upd_cnt[7:0], 8'h01);
        peek(8'h10, 8'hA5);
        host_u.frame(1'b1, 2'h0, 13'h0010, 1, 1'b0);
        check(host_u.rb[0], 8'hA5);
        host_u.frame(1'b1, 2'h0, XFER_ADDR, 1, 1'b0);
        check(host_u.rb[0], 8'h00);
        host_u.wb = '{8'h77, 8'h88, 8'h00, 8'h00};
        host_u.frame(1'b0, 2'h0, 13'h0041, 2, 1'b0);
        host_u.frame(1'b1, 2'h1, 13'h0041, 2, 1'b0);
        check(host_u.rb[0], 8'h77);
        check(host_u.rb[1], 8'h00);
        $display("test write read done");
        host_u.wb = '{8'h11, 8'h22, 8'h33, 8'h44};
        host_u.frame(1'b0, WLEN_STREAM, 13'h0022, 3, 1'b0);
        host_u.wb = '{8'h00, 8'h00, 8'h00, 8'h00};
        host_u.frame(1'b1, 2'h2, 13'h0022, 3, 1'b1);
        for (int k = 0; k < 3; k++) begin
            check(host_u.rb[k], 8'(8'h11 * (k + 1)));
        end
        $display("test stream stall done");
        host_u.o_csn = 1'b0;
        host_u.shift(4, 16'h000F, r);
        host_u.o_csn = 1'b1;
        host_u.wt(8);
        check({6'h0, sec, busy}, 8'h02);
        $display("test abort done");
        wr(CFG_ADDR, 8'h42);
        check({7'h0, lsbf}, 8'h01);
        host_u.lsb = 1'b1;
        host_u.wb = '{8'h5A, 8'hC3, 8'h00, 8'h00};
        host_u.frame(1'b0, WLEN_STREAM, 13'h0030, 2, 1'b0);
        host_u.frame(1'b1, 2'h1, 13'h0031, 2, 1'b0);
        check(host_u.rb[0], 8'hC3);
        wr(CFG_ADDR, 8'h18);
        host_u.lsb = 1'b0;
        check({7'h0, lsbf}, 8'h00);
        host_u.frame(1'b1, 2'h0, 13'h0030, 1, 1'b0);
        check(host_u.rb[0], 8'h5A);
        $display("test bit order done");
        tally_and_finish();
    end
endmodule : tb
